// ==== common/dcf_mem_if.sv ====
// Carrier between the channel control logic and its storage array.
// Both ends run on clk_sys.
`timescale 1ns/10ps
interface dcf_mem_if;
  import dcf_pkg::*;
  logic      wrEn;
  dcf_addr_t wrAddr;
  dcf_word_t wrData;
  logic      rdEn;
  dcf_addr_t rdAddr;
  dcf_word_t rdData;

  modport ctrl  (output wrEn, wrAddr, wrData, rdEn, rdAddr,
                 input  rdData);
  modport store (input  wrEn, wrAddr, wrData, rdEn, rdAddr,
                 output rdData);
endinterface

// ==== common/dcf_pkg.sv ====
// Types shared by the FIFO channel, its memory and their interface.
// Expects dcf_regs.svh on the include path.
`include "dcf_regs.svh"

package dcf_pkg;
  typedef logic [`DCF_AW:0]     dcf_ptr_t;   // Pointer with wrap bit
  typedef logic [`DCF_AW-1:0]   dcf_addr_t;
  typedef logic [`DCF_DW-1:0]   dcf_word_t;
  typedef logic [`DCF_OFFW-1:0] dcf_byte_t;
  typedef logic [1:0]           dcf_sel_t;   // Offset sequence position

  // Configuration caught while reset is held
  typedef enum logic {
    MODE_PROG_FLAGS,
    MODE_TWO_WE
  } dcf_mode_e;
endpackage

// ==== common/dcf_regs.svh ====
// Constants of one programmable-flag FIFO channel: sizes, offset
// register sequence positions, reset defaults of the offset bytes.
// Included by the package and the design files; guarded, so a repeat
// include is harmless. Holds definitions and nothing else.
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// Storage size; the address width must match the depth
`define DCF_DEPTH      256
`define DCF_AW         8
`define DCF_DW         9
`define DCF_OFFW       8

// Position of each offset register in the load/readback sequence
`define DCF_SEQ_EMPTY_LO  2'h0
`define DCF_SEQ_EMPTY_HI  2'h1
`define DCF_SEQ_FULL_LO   2'h2
`define DCF_SEQ_FULL_HI   2'h3
`define DCF_SEQ_COUNT     4

// Default offsets: 7 words for both programmable flags
`define DCF_EMPTY_LO_DEF  8'h07
`define DCF_EMPTY_HI_DEF  8'h00
`define DCF_FULL_LO_DEF   8'h07
`define DCF_FULL_HI_DEF   8'h00

// Output data register after reset
`define DCF_DOUT_DEF      9'h000

`endif

// ==== hdl/dcf_mem.sv ====
// Storage array of the FIFO channel, one write and one read port.
// Read data come out of a register one clk_sys cycle after rdEn.
`timescale 1ns/10ps
`include "dcf_regs.svh"
module dcf_mem
  import dcf_pkg::*;
(
  input  wire logic clk_sys,   // System clock
  dcf_mem_if.store  bus        // Port from the control logic
);
  dcf_word_t store [`DCF_DEPTH];

  // No reset on the array; contents are only read after a write
  always_ff @(posedge clk_sys)
  begin
    if (bus.wrEn)
      store[bus.wrAddr] <= bus.wrData;
  end

  // Registered read port
  always_ff @(posedge clk_sys)
  begin
    if (bus.rdEn)
      bus.rdData <= store[bus.rdAddr];
  end
endmodule

// ==== hdl/dcf_top.sv ====
// One programmable-flag FIFO channel with write and read clock pins.
// Assumes the write and read clock pins are synchronous inputs to
// clk_sys and each stays high and low for at least one clk_sys cycle.
//
// Summary of operation
// - Reset low sets read and write pointers to location zero.
// - Reset drives full flags high, empty flags low.
// - Reset zeroes the output register and restores offset defaults.
// - Writes and full-side flags act on the write clock rising edge.
// - Write and read clocks may be unrelated or the same clock.
// - Flag mode: first write enable low stores the word in sequence.
// - Without a write enable nothing is stored.
// - Full flag low blocks writes; a read later releases it.
// - Both read enables low move the next word to the output.
// - Either read enable high holds output and read pointer.
// - Empty flag low blocks reads; a write later releases it.
// - Output enable low drives the data bus, high floats it.
// - Second-enable/load pin sampled during reset selects the mode.
// - Two-enable mode writes only with first low and second high.
// - Four 8-bit offset registers, loadable and readable.
// - Load low with write enable low loads offsets in wrapping order.
// - Load high resumes normal work; sequence position is kept.
// - Load low with reads enabled reads offsets back in same order.
// - Unprogrammed empty and full offsets are both seven.
// - Almost-full goes low at depth minus full offset words.
// - Almost-empty is low while word count is at most empty offset.
// - Full after exactly depth writes; depth is 256 here.
`timescale 1ns/10ps
`include "dcf_regs.svh"
module dcf_top
  import dcf_pkg::*;
(
  input  wire logic      clk_sys,                 // 20 MHz clock
  input  wire logic      resetn,                  // Async reset, low
  input  wire logic      writeClock,              // Write clock pin
  input  wire logic      readClock,               // Read clock pin
  input  wire dcf_word_t writeDataIn,             // Data to store
  input  wire logic      writeEnableFirstN,       // Write enable, low
  input  wire logic      writeEnableSecondOrLoad, // Enable 2 / load_n
  input  wire logic      readEnableFirstN,        // Read enable, low
  input  wire logic      readEnableSecondN,       // Read enable, low
  input  wire logic      outputDriveEnableN,      // Bus drive, low
  output dcf_word_t      readDataOut,             // Output register
  output logic           readDataOutEn,           // Bus driven when 1
  output logic           fullFlagN,               // Full, low
  output logic           emptyFlagN,              // Empty, low
  output logic           almostFullFlagN,         // Almost full, low
  output logic           almostEmptyFlagN         // Almost empty, low
);

  // Effective offset: byte pair cut to the pointer's address width
  function automatic dcf_ptr_t effOffset(input dcf_byte_t lo,
                                         input dcf_byte_t hi);
    logic [2*`DCF_OFFW-1:0] pair;
    pair = {hi, lo};
    return {1'b0, pair[`DCF_AW-1:0]};
  endfunction

  // Reset value of each offset register by sequence position
  function automatic dcf_byte_t offDefault(input int idx);
    case (idx)
      0:       return `DCF_EMPTY_LO_DEF;
      1:       return `DCF_EMPTY_HI_DEF;
      2:       return `DCF_FULL_LO_DEF;
      default: return `DCF_FULL_HI_DEF;
    endcase
  endfunction

  localparam dcf_ptr_t DepthCount = dcf_ptr_t'(`DCF_DEPTH);

  logic      writeClockPrev;
  logic      readClockPrev;
  logic      wrRise;
  logic      rdRise;
  dcf_mode_e mode;
  logic      progMode;
  logic      offLoadReq;
  logic      dataWrReq;
  logic      readBoth;
  logic      offReadReq;
  logic      doWrite;
  logic      doOffLoad;
  logic      doRead;
  logic      doOffRead;
  logic      readPend;
  dcf_ptr_t  wrPtr;
  dcf_ptr_t  rdPtr;
  dcf_ptr_t  next_wrPtr;
  dcf_ptr_t  next_rdPtr;
  dcf_ptr_t  wrCount;
  dcf_ptr_t  rdCount;
  dcf_ptr_t  emptyOff;
  dcf_ptr_t  fullOff;
  dcf_ptr_t  afThreshold;
  dcf_sel_t  wrSeq;
  dcf_sel_t  rdSeq;
  dcf_byte_t offReg [`DCF_SEQ_COUNT];

  dcf_mem_if memBus ();

  // Rising edges of the clock pins, seen in the clk_sys domain; any
  // phase relation between them works, including one shared clock
  assign wrRise = writeClock & ~writeClockPrev;
  assign rdRise = readClock & ~readClockPrev;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      writeClockPrev <= 1'b0;
      readClockPrev  <= 1'b0;
    end
    else
    begin
      writeClockPrev <= writeClock;
      readClockPrev  <= readClock;
    end
  end

  // Mode pin is caught on every clock while reset is low, so the
  // value present when reset releases is the one that sticks
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      mode <= writeEnableSecondOrLoad ? MODE_TWO_WE
                                      : MODE_PROG_FLAGS;
  end

  assign progMode = (mode == MODE_PROG_FLAGS);

  // Write side decode; the pin reads as enable 2 or as load_n
  assign offLoadReq = progMode && !writeEnableFirstN
                      && !writeEnableSecondOrLoad;
  assign dataWrReq  = progMode ? (!writeEnableFirstN
                                  && writeEnableSecondOrLoad)
                               : (!writeEnableFirstN
                                  && writeEnableSecondOrLoad);
  assign doWrite    = wrRise && dataWrReq && fullFlagN;
  assign doOffLoad  = wrRise && offLoadReq;

  // Read side decode; offset readback replaces data reads
  assign readBoth   = !readEnableFirstN && !readEnableSecondN;
  assign offReadReq = progMode && !writeEnableSecondOrLoad
                      && readBoth;
  assign doOffRead  = rdRise && offReadReq;
  assign doRead     = rdRise && readBoth && !offReadReq
                      && emptyFlagN;

  // Pointer arithmetic and occupancy seen by each side
  assign next_wrPtr  = wrPtr + dcf_ptr_t'(doWrite);
  assign next_rdPtr  = rdPtr + dcf_ptr_t'(doRead);
  assign wrCount     = next_wrPtr - rdPtr;
  assign rdCount     = wrPtr - next_rdPtr;
  assign emptyOff    = effOffset(offReg[`DCF_SEQ_EMPTY_LO],
                                 offReg[`DCF_SEQ_EMPTY_HI]);
  assign fullOff     = effOffset(offReg[`DCF_SEQ_FULL_LO],
                                 offReg[`DCF_SEQ_FULL_HI]);
  assign afThreshold = DepthCount - fullOff;

  // Storage port connections
  assign memBus.wrEn   = doWrite;
  assign memBus.wrAddr = wrPtr[`DCF_AW-1:0];
  assign memBus.wrData = writeDataIn;
  assign memBus.rdEn   = doRead;
  assign memBus.rdAddr = rdPtr[`DCF_AW-1:0];

  dcf_mem uMem (
    .clk_sys (clk_sys),
    .bus     (memBus.store)
  );

  // Pointers; only the matching edge moves each one
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // Full-side flags change only on a write clock edge. Both pointers
  // live in one domain and flags come from flip-flops, so no glitch.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fullFlagN       <= 1'b1;
      almostFullFlagN <= 1'b1;
    end
    else if (wrRise)
    begin
      fullFlagN       <= !(wrCount == DepthCount);
      almostFullFlagN <= !(wrCount >= afThreshold);
    end
  end

  // Empty-side flags change only on a read clock edge; a write seen
  // in the same cycle shows at the following read edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      emptyFlagN       <= 1'b0;
      almostEmptyFlagN <= 1'b0;
    end
    else if (rdRise)
    begin
      emptyFlagN       <= !(rdCount == '0);
      almostEmptyFlagN <= !(rdCount <= emptyOff);
    end
  end

  // Offset registers, one process each, loaded at the write sequence
  genvar g;
  generate
    for (g = 0; g < `DCF_SEQ_COUNT; g++)
    begin : gOffset
      // Elaboration-time constant keeps the reset branch a plain value
      localparam dcf_byte_t ResetByte = offDefault(g);
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
          offReg[g] <= ResetByte;
        else if (doOffLoad && wrSeq == dcf_sel_t'(g))
          offReg[g] <= writeDataIn[`DCF_OFFW-1:0];
      end
    end
  endgenerate

  // Sequence positions survive leaving load mode; wrap after four
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrSeq <= `DCF_SEQ_EMPTY_LO;
      rdSeq <= `DCF_SEQ_EMPTY_LO;
    end
    else
    begin
      if (doOffLoad)
        wrSeq <= wrSeq + 2'h1;
      if (doOffRead)
        rdSeq <= rdSeq + 2'h1;
    end
  end

  // Storage read data land one cycle after the read is issued
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      readPend <= 1'b0;
    else
      readPend <= doRead;
  end

  // Output register: offsets read back at once, data via the array;
  // two sources never collide as read edges are two cycles apart
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      readDataOut <= `DCF_DOUT_DEF;
    else if (doOffRead)
      readDataOut <= {1'b0, offReg[rdSeq]};
    else if (readPend)
      readDataOut <= memBus.rdData;
  end

  // Bus drive enable, registered so the output comes from a flop
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      readDataOutEn <= 1'b0;
    else
      readDataOutEn <= !outputDriveEnableN;
  end

  // Checks on the behaviour above
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence sFullEdge;
    wrRise && !fullFlagN;
  endsequence

  sequence sLoadStep;
    wrRise && offLoadReq;
  endsequence

  sequence sHeldRead;
    rdRise && !readBoth;
  endsequence

  a_reset_flags_out: assert property (
    $rose(resetn) |-> fullFlagN && almostFullFlagN
                      && !emptyFlagN && !almostEmptyFlagN)
    else $error("flags wrong after reset");

  a_reset_clears_state: assert property (
    $rose(resetn) |-> wrPtr == '0 && rdPtr == '0
                      && readDataOut == '0)
    else $error("pointers or output not cleared by reset");

  a_write_advances: assert property (
    doWrite |=> wrPtr == $past(wrPtr) + 9'h001)
    else $error("write did not advance pointer");

  a_full_blocks_write: assert property (
    sFullEdge |=> wrPtr == $past(wrPtr))
    else $error("write taken while full");

  a_full_edge_only: assert property (
    !wrRise |=> $stable(fullFlagN) && $stable(almostFullFlagN))
    else $error("full-side flag moved off write edge");

  a_two_we_hold: assert property (
    wrRise && !progMode && !writeEnableSecondOrLoad
    |=> $stable(wrPtr))
    else $error("two-enable mode wrote with enable 2 low");

  a_read_hold: assert property (
    sHeldRead |=> $stable(rdPtr) ##1 $stable(readDataOut))
    else $error("read happened with a read enable high");

  a_empty_blocks_read: assert property (
    rdRise && !emptyFlagN |=> $stable(rdPtr))
    else $error("read taken while empty");

  a_read_data_lands: assert property (
    doRead |=> readPend ##1 readDataOut == $past(memBus.rdData))
    else $error("read word not in output register");

  a_load_sequence: assert property (
    sLoadStep |=> wrSeq == $past(wrSeq) + 2'h1
                  && offReg[$past(wrSeq)] == $past(writeDataIn[7:0]))
    else $error("offset load out of sequence");

  a_full_at_depth: assert property (
    wrRise && wrCount == DepthCount |=> !fullFlagN && !almostFullFlagN)
    else $error("full flag missing at depth");

  a_drive_follows: assert property (
    $fell(outputDriveEnableN) |=> readDataOutEn)
    else $error("bus not driven after enable");

endmodule

// ==== tb/dcf_peer.sv ====
// Producer and consumer in front of one FIFO channel.
// Assumes the bench calls one task at a time, except one fork.
`timescale 1ns/10ps
module dcf_peer
  import dcf_pkg::*;
(
  input  wire logic      clk_sys,                 // System clock
  input  wire dcf_word_t readDataOut,             // Output register
  output dcf_word_t      writeDataIn,             // Word to store
  output logic           writeClock,              // Write clock pin
  output logic           readClock,               // Read clock pin
  output logic           writeEnableFirstN,       // Write enable, low
  output logic           writeEnableSecondOrLoad, // Enable 2 / load_n
  output logic           readEnableFirstN,        // Read enable, low
  output logic           readEnableSecondN        // Read enable, low
);
  // Idle pins; clocks low so reset release sees no edge
  initial
  begin
    writeDataIn             = 9'h000;
    writeClock              = 1'b0;
    readClock               = 1'b0;
    writeEnableFirstN       = 1'b1;
    writeEnableSecondOrLoad = 1'b1;
    readEnableFirstN        = 1'b1;
    readEnableSecondN       = 1'b1;
  end

  // Strap or load pin, changed off the sampling edge
  task automatic pin(input logic v);
    @(negedge clk_sys);
    writeEnableSecondOrLoad = v;
  endtask

  // Write clock high one cycle with the enables held, then low
  task automatic wr(input dcf_word_t d, input logic e1n, input logic e2);
    @(negedge clk_sys);
    writeDataIn             = d;
    writeEnableFirstN       = e1n;
    writeEnableSecondOrLoad = e2;
    writeClock              = 1'b1;
    @(negedge clk_sys);
    writeClock        = 1'b0;
    writeEnableFirstN = 1'b1;
    writeDataIn       = ~d;  // Released bus never shows the last word
  endtask

  // Read pulse; the word lands two cycles after the taken edge.
  // Only one of load or readback runs at a time.
  task automatic rd(input logic r1n, input logic r2n,
                    output dcf_word_t q);
    @(negedge clk_sys);
    readEnableFirstN  = r1n;
    readEnableSecondN = r2n;
    readClock         = 1'b1;
    @(negedge clk_sys);
    readClock         = 1'b0;
    readEnableFirstN  = 1'b1;
    readEnableSecondN = 1'b1;
    repeat (2) @(negedge clk_sys);
    q = readDataOut;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for one FIFO channel: reset, offsets, fill,
// drain, two-enable mode. Pins are driven through dcf_peer.
`timescale 1ns/10ps
module tb;
  import dcf_pkg::*;
  logic      clk_sys            = 1'b0;
  logic      resetn             = 1'b0;
  logic      outputDriveEnableN = 1'b1;
  dcf_word_t writeDataIn, readDataOut, q;
  logic      writeClock, readClock, writeEnableFirstN;
  logic      writeEnableSecondOrLoad, readEnableFirstN, readEnableSecondN;
  logic      readDataOutEn, fullFlagN, emptyFlagN;
  logic      almostFullFlagN, almostEmptyFlagN;
  int        fail_count = 0;
  int        tests_run  = 0;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  dcf_peer peer (
    .clk_sys(clk_sys), .readDataOut(readDataOut),
    .writeDataIn(writeDataIn), .writeClock(writeClock),
    .readClock(readClock), .writeEnableFirstN(writeEnableFirstN),
    .writeEnableSecondOrLoad(writeEnableSecondOrLoad),
    .readEnableFirstN(readEnableFirstN),
    .readEnableSecondN(readEnableSecondN)
  );

  dcf_top DUT (
    .clk_sys(clk_sys), .resetn(resetn), .writeClock(writeClock),
    .readClock(readClock), .writeDataIn(writeDataIn),
    .writeEnableFirstN(writeEnableFirstN),
    .writeEnableSecondOrLoad(writeEnableSecondOrLoad),
    .readEnableFirstN(readEnableFirstN),
    .readEnableSecondN(readEnableSecondN),
    .outputDriveEnableN(outputDriveEnableN),
    .readDataOut(readDataOut), .readDataOutEn(readDataOutEn),
    .fullFlagN(fullFlagN), .emptyFlagN(emptyFlagN),
    .almostFullFlagN(almostFullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN)
  );

  // Odd step keeps all 256 words distinct
  function automatic dcf_word_t wd(input int i);
    return dcf_word_t'(i * 5 + 3);
  endfunction

  // Flags as {full, almost full, empty, almost empty}
  function automatic dcf_word_t fl();
    return {5'h00, fullFlagN, almostFullFlagN,
            emptyFlagN, almostEmptyFlagN};
  endfunction

  task automatic chk(input dcf_word_t got, input dcf_word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  // Strap pin is set one cycle into reset and held to release; three cycles low
  task automatic reset_dut(input logic strap);
    resetn = 1'b0;
    peer.pin(strap);
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    reset_dut(1'b0);
    chk(fl(), 9'h00c);
    chk(readDataOut, 9'h000);
    chk({8'h00, readDataOutEn}, 9'h000);
    @(negedge clk_sys);
    outputDriveEnableN = 1'b0;
    @(negedge clk_sys);
    chk({8'h00, readDataOutEn}, 9'h001);
    done("reset");
    for (int i = 0; i < 4; i++)
    begin
      peer.rd(1'b0, 1'b0, q);
      chk(q, (i % 2 == 0) ? 9'h007 : 9'h000);
    end
    done("default offsets");
    peer.wr(9'h103, 1'b0, 1'b0);
    peer.wr(9'h100, 1'b0, 1'b0);
    peer.wr(9'h1aa, 1'b1, 1'b1);
    peer.wr(9'h105, 1'b0, 1'b0);
    peer.wr(9'h000, 1'b0, 1'b0);
    peer.wr(9'h002, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      peer.rd(1'b0, 1'b0, q);
      chk(q, (i == 0) ? 9'h002 : (i == 2) ? 9'h005 : 9'h000);
    end
    chk(fl(), 9'h00c);
    done("offset load");
    // Empty offset now 2, full offset 5
    for (int i = 0; i < 256; i++)
    begin
      peer.wr(wd(i), 1'b0, 1'b1);
      if (i == 1 || i == 2)
      begin
        peer.rd(1'b0, 1'b1, q);
        chk(q, 9'h000);
        chk(fl(), (i == 1) ? 9'h00e : 9'h00f);
      end
      if (i >= 249)
        chk(fl(), {5'h00, i != 255, i < 250, 2'b11});
    end
    peer.wr(9'h1fe, 1'b0, 1'b1);
    chk(fl(), 9'h003);
    peer.rd(1'b0, 1'b0, q);
    chk(q, wd(0));
    peer.wr(9'h1fe, 1'b1, 1'b1);
    chk(fl(), 9'h00b);
    done("fill");
    for (int i = 1; i < 256; i++)
    begin
      peer.rd(1'b0, 1'b0, q);
      chk(q, wd(i));
    end
    peer.rd(1'b0, 1'b0, q);
    peer.wr(9'h1fe, 1'b1, 1'b1);
    chk(q, wd(255));
    chk(fl(), 9'h00c);
    done("drain");
    peer.wr(9'h011, 1'b0, 1'b1);
    reset_dut(1'b1);
    chk(fl(), 9'h00c);
    chk(readDataOut, 9'h000);
    peer.wr(9'h0a1, 1'b0, 1'b0);
    peer.wr(9'h0a2, 1'b1, 1'b1);
    peer.wr(9'h0a3, 1'b0, 1'b1);
    peer.wr(9'h0a4, 1'b0, 1'b0);
    peer.rd(1'b1, 1'b1, q);
    chk(fl(), 9'h00e);
    peer.rd(1'b0, 1'b0, q);
    chk(q, 9'h0a3);
    peer.rd(1'b0, 1'b0, q);
    chk(q, 9'h0a3);
    // Write and read edges in the same cycle
    fork
      peer.wr(9'h0b5, 1'b0, 1'b1);
      peer.rd(1'b1, 1'b1, q);
    join
    peer.rd(1'b0, 1'b1, q);
    peer.rd(1'b0, 1'b0, q);
    chk(q, 9'h0b5);
    // Releasing the output enable must drop the bus drive again
    @(negedge clk_sys);
    outputDriveEnableN = 1'b1;
    @(negedge clk_sys);
    chk({8'h00, readDataOutEn}, 9'h000);
    done("two enables");
    wrap_up();
  end

  // Watchdog: the sequence needs about 1700 cycles, limit is 4000
  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected timeout at %0t", $time);
    wrap_up();
  end
endmodule
